// file: common/sarc_pkg.sv
package sarc_pkg;
   // ----------------------------------------
   // Data layout
   // ----------------------------------------
   localparam int unsigned RAW_W      = 25;
   localparam int unsigned DIFF_W     = 24;
   localparam int unsigned CM_W       = 8;
   localparam int unsigned WORD_W     = 32;
   localparam int unsigned GAIN_W     = 16;
   localparam int unsigned GAIN_SHIFT = 15;
   localparam int unsigned AVG_N_W    = 5;
   localparam int unsigned ACC_W      = 41;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam logic [23:0] DIFF_MAX   = 24'h7fffff;
   localparam logic [23:0] DIFF_MIN   = 24'h800000;
   localparam logic [15:0] GAIN_UNITY = 16'h8000;
   localparam logic [31:0] OUT_RESET  = 32'h00000000;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CONV_TIME_NS  = 300;
   localparam int unsigned CONV_CYCLES   =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_ACQ  = 4'b0001,
      ST_CONV = 4'b0010,
      ST_PROC = 4'b0100,
      ST_PUSH = 4'b1000
   } sarc_state_e;
endpackage

// file: common/sarc_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sarc_stream_if #(parameter int unsigned W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: design/sarc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sarc_fifo #(
   parameter int unsigned W     = 32,
   parameter int unsigned DEPTH = 32
) (
   input wire logic    i_clk,
   input wire logic    i_srst,
   sarc_stream_if.snk  s_in,
   sarc_stream_if.src  s_out
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]   cnt_reg, cnt_next;
   logic          push, pop;

   assign s_in.ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign s_out.valid = (cnt_reg != '0);
   assign s_out.data  = mem_reg[rd_reg];

   always_comb begin
      push     = s_in.valid && s_in.ready;
      pop      = s_out.valid && s_out.ready;
      wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= s_in.data;
      end
      if (i_srst) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

// file: design/sarc_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Sequencer alternates between acquisition and conversion phases.
// - Host rising edge on convert_start begins a conversion; device starts on it.
// - Busy rises on the same detected convert_start rising edge.
// - Busy falls when the conversion completes and its result is stored, or added to a partial average.
// - Each conversion yields a 24-bit difference code and 8-bit common-mode code.
// - Result is optionally processed, then latched into the output register.
// - Output register is shifted out on the serial data lane for the host.
// - Difference code is twos complement.
// - Default mapping: full range onto 2^24 codes, 0x800000 to 0x7fffff.
// - Zero difference gives 0x000000; one step up 0x000001, down 0xffffff.
// - Offset and gain results beyond signed 24-bit range saturate at limits.
// - Gain at or below 64/65 of unity converts inputs up to 65/64 reference unsaturated.
// - No pipeline latency: each result belongs to the conversion just started.
// - First conversion after leaving power-down is already valid.
// - Offset, gain and averaging each switch on or off by configuration.
// - With chip select low, the result shifts out on falling serial clock edges.
module sarc_top #(
   parameter int unsigned FIFO_DEPTH = sarc_pkg::FIFO_DEPTH
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_srst,
   input  wire logic                        i_convert_start,
   input  wire logic                        i_power_down,
   input  wire logic                        i_cs_n,
   input  wire logic                        i_sck,
   input  wire logic signed [24:0]          i_sample_diff,
   input  wire logic [7:0]                  i_sample_cm,
   input  wire logic                        i_offset_en,
   input  wire logic [23:0]                 i_offset,
   input  wire logic                        i_gain_en,
   input  wire logic [15:0]                 i_gain,
   input  wire logic                        i_avg_en,
   input  wire logic [4:0]                  i_avg_log2,
   output logic                             o_busy,
   output logic                             o_sdo
);
   localparam int unsigned WW = sarc_pkg::WORD_W;

   // ----------------------------------------
   // Pin synchronisers: convert, power-down, cs, sck
   // ----------------------------------------
   logic [3:0] s1_reg, s2_reg, s3_reg;
   logic       cnv_rise, pd_s, cs_fall, cs_low, sck_fall;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s1_reg <= 4'h6;
         s2_reg <= 4'h6;
         s3_reg <= 4'h6;
      end else begin
         s1_reg <= {i_sck, i_cs_n, i_power_down, i_convert_start};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign cnv_rise = s2_reg[0] && !s3_reg[0];
   assign pd_s     = s2_reg[1];
   assign cs_fall  = !s2_reg[2] && s3_reg[2];
   assign cs_low   = !s2_reg[2];
   assign sck_fall = !s2_reg[3] && s3_reg[3];

   // ----------------------------------------
   // Saturation to signed 24 bits
   // ----------------------------------------
   function automatic logic [23:0] sat24(input logic signed [41:0] v);
      if (v > 42'sh7fffff) begin
         sat24 = sarc_pkg::DIFF_MAX;
      end else if (v < -42'sh800000) begin
         sat24 = sarc_pkg::DIFF_MIN;
      end else begin
         sat24 = v[23:0];
      end
   endfunction

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   sarc_pkg::sarc_state_e state_reg, state_next;
   logic [3:0]            cnt_reg, cnt_next;
   logic                  busy_reg, busy_next;
   logic signed [24:0]    raw_reg, raw_next;
   logic [7:0]            cm_reg, cm_next;
   logic [WW-1:0]         word_reg, word_next;
   logic signed [40:0]    acc_reg, acc_next;
   logic [16:0]           nblk_reg, nblk_next;
   logic signed [41:0]    gained, offs;
   logic [23:0]           proc_diff;
   logic signed [40:0]    acc_sum;
   logic                  fifo_in_ready;

   sarc_stream_if #(.W(WW)) fin ();
   sarc_stream_if #(.W(WW)) fout ();

   assign fin.valid     = (state_reg == sarc_pkg::ST_PUSH);
   assign fin.data      = word_reg;
   assign fifo_in_ready = fin.ready;

   always_comb begin
      gained = 42'(raw_reg);
      if (i_gain_en) begin
         // Unsigned gain, unity at half scale
         gained = 42'(($signed(42'(raw_reg)) * $signed({26'h0, i_gain}))
                  >>> sarc_pkg::GAIN_SHIFT);
      end
      offs = 42'(sat24(gained));
      offs = $signed({{18{offs[23]}}, offs[23:0]});
      if (i_offset_en) begin
         offs = offs + $signed({{18{i_offset[23]}}, i_offset});
      end
      proc_diff = sat24(offs);
      acc_sum   = acc_reg + $signed({{17{proc_diff[23]}}, proc_diff});
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      busy_next  = busy_reg;
      raw_next   = raw_reg;
      cm_next    = cm_reg;
      word_next  = word_reg;
      acc_next   = acc_reg;
      nblk_next  = nblk_reg;
      case (state_reg)
         sarc_pkg::ST_ACQ: begin
            // Track and hold; power-down only holds off edges, keeping any partial average
            if (cnv_rise && !pd_s) begin
               state_next = sarc_pkg::ST_CONV;
               busy_next  = 1'b1;
               cnt_next   = 4'(sarc_pkg::CONV_CYCLES - 1);
               raw_next   = i_sample_diff;
               cm_next    = i_sample_cm;
            end
         end
         sarc_pkg::ST_CONV: begin
            if (cnt_reg == 4'h0) begin
               state_next = sarc_pkg::ST_PROC;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         sarc_pkg::ST_PROC: begin
            if (i_avg_en) begin
               if (17'(nblk_reg + 1'b1) == (17'h1 << i_avg_log2)) begin
                  word_next  = {24'(acc_sum >>> i_avg_log2), cm_reg};
                  acc_next   = '0;
                  nblk_next  = '0;
                  state_next = sarc_pkg::ST_PUSH;
               end else begin
                  acc_next   = acc_sum;
                  nblk_next  = 17'(nblk_reg + 1'b1);
                  busy_next  = 1'b0;
                  state_next = sarc_pkg::ST_ACQ;
               end
            end else begin
               word_next  = {proc_diff, cm_reg};
               acc_next   = '0;
               nblk_next  = '0;
               state_next = sarc_pkg::ST_PUSH;
            end
         end
         sarc_pkg::ST_PUSH: begin
            // A full buffer stalls here and holds busy high
            if (fifo_in_ready) begin
               busy_next  = 1'b0;
               state_next = sarc_pkg::ST_ACQ;
            end
         end
         default: begin
            state_next = sarc_pkg::ST_ACQ;
            busy_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= sarc_pkg::ST_ACQ;
         cnt_reg   <= '0;
         busy_reg  <= 1'b0;
         raw_reg   <= '0;
         cm_reg    <= '0;
         word_reg  <= sarc_pkg::OUT_RESET;
         acc_reg   <= '0;
         nblk_reg  <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         busy_reg  <= busy_next;
         raw_reg   <= raw_next;
         cm_reg    <= cm_next;
         word_reg  <= word_next;
         acc_reg   <= acc_next;
         nblk_reg  <= nblk_next;
      end
   end

   assign o_busy = busy_reg;

   sarc_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .s_in   (fin.snk),
      .s_out  (fout.src)
   );

   // ----------------------------------------
   // Serial output: load at cs fall, shift on sck fall
   // ----------------------------------------
   logic [WW-1:0] out_reg, out_next, shift_reg, shift_next;
   logic          sdo_reg, sdo_next;

   // Empty buffer at frame start resends the last result
   assign fout.ready = cs_fall;

   always_comb begin
      out_next   = out_reg;
      shift_next = shift_reg;
      sdo_next   = sdo_reg;
      if (cs_fall) begin
         if (fout.valid) begin
            out_next = fout.data;
         end
         sdo_next   = out_next[WW-1];
         shift_next = {out_next[WW-2:0], 1'b0};
      end else if (cs_low && sck_fall) begin
         sdo_next   = shift_reg[WW-1];
         shift_next = {shift_reg[WW-2:0], 1'b0};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         out_reg   <= sarc_pkg::OUT_RESET;
         shift_reg <= '0;
         sdo_reg   <= 1'b0;
      end else begin
         out_reg   <= out_next;
         shift_reg <= shift_next;
         sdo_reg   <= sdo_next;
      end
   end

   assign o_sdo = sdo_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   property p_busy_start;
      (state_reg == sarc_pkg::ST_ACQ) && cnv_rise && !pd_s |=> o_busy && (state_reg == sarc_pkg::ST_CONV);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy not raised on start");

   property p_conv_len;
      $rose(state_reg == sarc_pkg::ST_CONV) |-> (state_reg == sarc_pkg::ST_CONV)[*3] ##1 (state_reg == sarc_pkg::ST_PROC);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion phase length wrong");

   property p_busy_end;
      (state_reg == sarc_pkg::ST_PUSH) && fifo_in_ready |=> !o_busy && (state_reg == sarc_pkg::ST_ACQ);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy not dropped at completion");

   property p_latency;
      $rose(o_busy) |-> ##[1:8] (state_reg == sarc_pkg::ST_PROC) && (raw_reg == $past(i_sample_diff, 4));
   endproperty
   a_latency: assert property (p_latency) else $error("result not from current sample");

   property p_default_code;
      (state_reg == sarc_pkg::ST_PROC) && !i_gain_en && !i_offset_en && !i_avg_en && (raw_reg[24] == raw_reg[23])
      |=> word_reg[31:8] == $past(raw_reg[23:0]);
   endproperty
   a_default_code: assert property (p_default_code) else $error("default code mismatch");

   property p_zero;
      (state_reg == sarc_pkg::ST_PROC) && !i_offset_en && !i_avg_en && (raw_reg == 25'sh0) |=> word_reg[31:8] == 24'h000000;
   endproperty
   a_zero: assert property (p_zero) else $error("zero input not zero code");

   property p_sat_hi;
      (state_reg == sarc_pkg::ST_PROC) && !i_avg_en && (offs > 42'sh7fffff) |=> word_reg[31:8] == sarc_pkg::DIFF_MAX;
   endproperty
   a_sat_hi: assert property (p_sat_hi) else $error("high saturation missing");

   property p_cm;
      (state_reg == sarc_pkg::ST_PROC) && !i_avg_en |=> word_reg[7:0] == $past(cm_reg);
   endproperty
   a_cm: assert property (p_cm) else $error("common-mode code lost");

   property p_shift;
      cs_low && sck_fall && !cs_fall |=> o_sdo == $past(shift_reg[31]);
   endproperty
   a_shift: assert property (p_shift) else $error("serial bit not shifted");

   c_push: cover property ((state_reg == sarc_pkg::ST_PUSH) && fifo_in_ready);
   c_full: cover property ((state_reg == sarc_pkg::ST_PUSH) && !fifo_in_ready);
   c_frame: cover property (cs_fall && fout.valid);
   c_avg: cover property ((state_reg == sarc_pkg::ST_PROC) && i_avg_en ##1 (state_reg == sarc_pkg::ST_PUSH));
endmodule
`default_nettype wire

// file: dv/sarc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sarc_host_model (
   input  wire logic        i_go,
   input  wire logic        i_sdo,
   output logic             o_cs_n,
   output logic             o_sck,
   output logic [31:0]      o_word,
   output logic             o_done
);
   // ----------------------------------------
   // Frame reader
   // ----------------------------------------
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_word = 32'h0;
      o_done = 1'b0;
   end
   // Clock only inside frames; 400 ns halves leave the sampled shift path time
   always @(posedge i_go) begin
      #37 o_cs_n = 1'b0;
      #600;
      for (int i = 31; i >= 0; i--) begin
         o_sck = 1'b1;
         o_word[i] = i_sdo;
         #400 o_sck = 1'b0;
         #400;
      end
      o_cs_n = 1'b1;
      o_done = 1'b1;
      #400 o_done = 1'b0;
   end
endmodule
`default_nettype wire

// file: dv/sarc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: %h seen, %h due", $time, (a), (b)); end end
module sarc_top_bench;
   logic               clk, srst, convert_start, pd, go, g_en, f_en, a_en, busy, sdo, cs_n, sck, done;
   logic signed [24:0] diff;
   logic [7:0]         cm;
   logic [23:0]        off;
   logic [15:0]        g;
   logic [4:0]         a_n;
   logic [31:0]        word, w, rnd, lastw;
   logic signed [40:0] acc;
   logic [31:0]        exp_q [$];
   int                 seed, num_errors, n_checks, acnt;
   logic signed [24:0] t [5] = '{25'sh1, -25'sd1, 25'sh7fffff, -25'sh800000, -25'sh7fffff};
   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   sarc_top #(.FIFO_DEPTH(32)) sarc_top_inst (.i_clk(clk), .i_srst(srst),
      .i_convert_start(convert_start), .i_power_down(pd), .i_cs_n(cs_n), .i_sck(sck),
      .i_sample_diff(diff), .i_sample_cm(cm), .i_offset_en(f_en), .i_offset(off),
      .i_gain_en(g_en), .i_gain(g), .i_avg_en(a_en), .i_avg_log2(a_n),
      .o_busy(busy), .o_sdo(sdo));
   sarc_host_model sarc_host_model_inst (.i_go(go), .i_sdo(sdo), .o_cs_n(cs_n),
      .o_sck(sck), .o_word(word), .o_done(done));
   // ----------------------------------------
   // Expectations and tasks
   // ----------------------------------------
   function automatic logic [23:0] sat(input logic signed [40:0] v);
      if (v > 41'sh7fffff) return 24'h7fffff;
      if (v < -41'sh800000) return 24'h800000;
      return v[23:0];
   endfunction
   function automatic logic [23:0] proc(input logic signed [24:0] d);
      logic signed [40:0] v;
      v = d;
      // Raw code clips to 24 bits before any offset is added
      if (g_en) v = (v * $signed({1'b0, g})) >>> 15;
      v = $signed(sat(v));
      if (f_en) v = $signed(sat(v + $signed(off)));
      return v[23:0];
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Full marks the conversion expected to stall on a full buffer
   task automatic conv(input logic signed [24:0] d, input logic [7:0] c, input bit full);
      int  n;
      bit  part;
      @(posedge clk);
      diff <= d;
      cm <= c;
      convert_start <= 1'b1;
      repeat (2) @(posedge clk);
      convert_start <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 6) begin
         @(posedge clk);
         n++;
      end
      `CHK(busy, 1'b1)
      n = 0;
      while (busy === 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      part = a_en && (acnt + 1 < (1 << a_n));
      if (full) `CHK(busy, 1'b1)
      else `CHK(n, part ? sarc_pkg::CONV_CYCLES + 1 : sarc_pkg::CONV_CYCLES + 2)
      if (a_en) begin
         acc += $signed(proc(d));
         acnt++;
         if (!part) begin
            exp_q.push_back({24'(acc >>> a_n), c});
            acc = 0;
            acnt = 0;
         end
      end else exp_q.push_back({proc(d), c});
   endtask
   task automatic rd();
      int n;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) num_errors++;
      repeat (6) @(posedge clk);
   endtask
   always @(posedge done) begin
      if (exp_q.size() == 0) begin
         num_errors++;
         $display("unexpected at %0t: word with no note", $time);
      end else begin
         w = exp_q.pop_front();
         `CHK(word, w)
      end
   end
   initial begin
      #5000000;
      num_errors++;
      test_done();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {srst, pd} = 2'b11;
      {convert_start, go, g_en, f_en, a_en} = 5'h0;
      {diff, cm, off, a_n} = '0;
      g = 16'h8000;
      {seed, num_errors, n_checks, acnt, acc} = '0;
      seed = 70;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      convert_start <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(busy, 1'b0)
      convert_start <= 1'b0;
      pd <= 1'b0;
      repeat (6) @(posedge clk);
      conv(25'sh0, 8'h5a, 0);
      rd();
      for (int i = 0; i < 5; i++) begin
         conv(t[i], 8'(i), 0);
         rd();
      end
      repeat (4) begin
         rnd = $random(seed);
         conv($signed(rnd[23:0]), rnd[31:24], 0);
      end
      repeat (4) rd();
      g_en <= 1'b1;
      g <= 16'h4000;
      conv(25'sh820000, 8'h11, 0);
      conv(-25'sh820000, 8'h22, 0);
      g <= 16'hffff;
      conv(25'sh7fffff, 8'h33, 0);
      g_en <= 1'b0;
      f_en <= 1'b1;
      off <= 24'h000010;
      conv(25'sh7ffff8, 8'h44, 0);
      conv(25'sh100, 8'h55, 0);
      off <= 24'hfffff0;
      conv(-25'sh7ffff8, 8'h66, 0);
      f_en <= 1'b0;
      conv(25'sh900000, 8'h77, 0);
      repeat (7) rd();
      a_en <= 1'b1;
      a_n <= 5'd1;
      conv(25'sd100, 8'h01, 0);
      conv(25'sd202, 8'h02, 0);
      conv(-25'sd6, 8'h03, 0);
      conv(-25'sd9, 8'h04, 0);
      a_en <= 1'b0;
      repeat (2) rd();
      for (int i = 0; i < 33; i++) begin
         rnd = $random(seed);
         conv($signed(rnd[23:0]), rnd[31:24], i == 32);
      end
      lastw = exp_q[$];
      repeat (33) rd();
      exp_q.push_back(lastw);
      rd();
      test_done();
   end
endmodule
`default_nettype wire
